// File: capture_fifo_readback_regs.sv
/*
 * register side of the capture memory: settle delay, readback mode,
 * status, readout word, read start offset, port dividers, self-test.
 * assumes a serial control front end that delivers one-cycle read and
 * write strobes with a 13-bit address; status inputs are same-clock.
 */
// How it works
// (R1) parallel port clock period is twice the 5-bit divider code
// (R2) parallel divider resets to code 00100, divide by eight
// (R3) divider codes with top bit set divide by 32; 01111 divides by 30
// (R4) status byte: full bit 0, empty bit 1, over-range bit 2, rest zero
// (R5) 12-bit readout word split into low byte and high nibble registers
// (R6) 14-bit read start offset from low byte plus six high bits
// (R7) 4-bit self-test selector picks ramp, checkerboards, PN or constant
// (R8) selector 0110 writes all-ones words
// (R9) selector 0101 writes word one; 0100 writes pseudo-random data
// (R10) capture from standby waits the 16-bit settle count before storing
// (R11) reserved bits ignore writes and read as zero
`timescale 1ns/10ps
`default_nettype none
module capture_fifo_readback_regs
   import capture_regs_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   input  wire logic [12:0]       regAddr,
   input  wire logic [7:0]        regWrData,
   input  wire logic              regWrite,
   input  wire logic              regRead,
   output logic [7:0]             regRdData,
   input  wire logic              fifoFull,
   input  wire logic              fifoEmpty,
   input  wire logic              overRange,
   input  wire logic [WORD_W-1:0] readoutWord,
   input  wire logic              readoutValid,
   input  wire logic              captureStart,
   input  wire logic              fromStandby,
   output logic                   storeEnable,
   output logic                   settling,
   output logic [13:0]            readStartOffset,
   output logic [MODE_W-1:0]      readbackMode,
   input  wire logic              parallelRun,
   input  wire logic              serialRun,
   output logic                   parallelPortClk,
   output logic                   serialPortClk,
   input  wire logic              testStep,
   output logic [WORD_W-1:0]      testWord,
   output logic                   testActive
);
   typedef enum logic [1:0] {IDLE, SETTLE, STORE} capture_state_t;

   logic [7:0]            settleLo_reg,  settleLo_next;
   logic [7:0]            settleHi_reg,  settleHi_next;
   logic [MODE_W-1:0]     mode_reg,      mode_next;
   logic [WORD_W-1:0]     word_reg,      word_next;
   logic [7:0]            startLo_reg,   startLo_next;
   logic [START_HI_W-1:0] startHi_reg,   startHi_next;
   logic [DIV_W-1:0]      pDiv_reg,      pDiv_next;
   logic [DIV_W-1:0]      sDiv_reg,      sDiv_next;
   logic [SEL_W-1:0]      sel_reg,       sel_next;
   logic [7:0]            rd_reg,        rd_next;
   capture_state_t        state_reg,     state_next;
   logic [15:0]           settleCnt_reg, settleCnt_next;
   logic [15:0]           settleTarget;
   logic [7:0]            flags;

   // --------------------------------------------------------------
   // register writes
   // --------------------------------------------------------------
   // only the documented field bits are stored, so reserved bits
   // cannot hold stale software values
   always_comb begin
      settleLo_next = settleLo_reg;
      settleHi_next = settleHi_reg;
      mode_next     = mode_reg;
      startLo_next  = startLo_reg;
      startHi_next  = startHi_reg;
      pDiv_next     = pDiv_reg;
      sDiv_next     = sDiv_reg;
      sel_next      = sel_reg;
      if (regWrite) begin
         unique case (regAddr)
            ADDR_SETTLE_LO: settleLo_next = regWrData;
            ADDR_SETTLE_HI: settleHi_next = regWrData;
            ADDR_MODE:      mode_next     = regWrData[MODE_W-1:0];     // [R11]
            ADDR_START_LO:  startLo_next  = regWrData;                 // [R6]
            ADDR_START_HI:  startHi_next  = regWrData[START_HI_W-1:0]; // [R6]
            ADDR_PDIV:      pDiv_next     = regWrData[DIV_W-1:0];      // [R1]
            ADDR_SDIV:      sDiv_next     = regWrData[DIV_W-1:0];
            ADDR_SELFTEST:  sel_next      = regWrData[SEL_W-1:0];      // [R7]
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         settleLo_reg <= SETTLE_RST;
         settleHi_reg <= SETTLE_RST;
         mode_reg     <= MODE_RST;
         startLo_reg  <= START_RST;
         startHi_reg  <= START_RST[START_HI_W-1:0];
         pDiv_reg     <= PDIV_RST;                                     // [R2]
         sDiv_reg     <= SDIV_RST;
         sel_reg      <= SEL_RST;
      end else begin
         settleLo_reg <= settleLo_next;
         settleHi_reg <= settleHi_next;
         mode_reg     <= mode_next;
         startLo_reg  <= startLo_next;
         startHi_reg  <= startHi_next;
         pDiv_reg     <= pDiv_next;
         sDiv_reg     <= sDiv_next;
         sel_reg      <= sel_next;
      end
   end

   // --------------------------------------------------------------
   // readout word holding and read mux
   // --------------------------------------------------------------
   // the word is held whole so both halves read back from one sample
   always_comb begin
      word_next = readoutValid ? readoutWord : word_reg;
      flags = '0;                                                      // [R4]
      flags[FLAG_FULL]  = fifoFull;                                    // [R4]
      flags[FLAG_EMPTY] = fifoEmpty;                                   // [R4]
      flags[FLAG_OVR]   = overRange;                                   // [R4]
      rd_next = rd_reg;
      if (regRead) begin
         unique case (regAddr)
            ADDR_SETTLE_LO: rd_next = settleLo_reg;
            ADDR_SETTLE_HI: rd_next = settleHi_reg;
            ADDR_MODE:      rd_next = {6'h00, mode_reg};               // [R11]
            ADDR_FLAGS:     rd_next = flags;
            ADDR_WORD_LO:   rd_next = word_reg[7:0];                   // [R5]
            ADDR_WORD_HI:   rd_next = {4'h0, word_reg[11:8]};          // [R5]
            ADDR_START_LO:  rd_next = startLo_reg;
            ADDR_START_HI:  rd_next = {2'h0, startHi_reg};             // [R11]
            ADDR_PDIV:      rd_next = {3'h0, pDiv_reg};                // [R11]
            ADDR_SDIV:      rd_next = {3'h0, sDiv_reg};                // [R11]
            ADDR_SELFTEST:  rd_next = {4'h0, sel_reg};                 // [R11]
            default:        rd_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         word_reg <= '0;
         rd_reg   <= 8'h00;
      end else begin
         word_reg <= word_next;
         rd_reg   <= rd_next;
      end
   end

   // --------------------------------------------------------------
   // settle wait before storing
   // --------------------------------------------------------------
   // a start not from standby skips the wait; a start during the wait or store is ignored
   assign settleTarget = {settleHi_reg, settleLo_reg};

   always_comb begin
      state_next     = state_reg;
      settleCnt_next = settleCnt_reg;
      unique case (state_reg)
         IDLE: begin
            if (captureStart && fromStandby) begin
               state_next     = SETTLE;                                // [R10]
               settleCnt_next = '0;
            end else if (captureStart) begin
               state_next = STORE;
            end
         end
         SETTLE: begin
            if (settleCnt_reg >= settleTarget) begin
               state_next = STORE;                                     // [R10]
            end else begin
               settleCnt_next = settleCnt_reg + 16'h0001;
            end
         end
         STORE: begin
            if (fifoFull) begin
               state_next = IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_reg     <= IDLE;
         settleCnt_reg <= '0;
      end else begin
         state_reg     <= state_next;
         settleCnt_reg <= settleCnt_next;
      end
   end

   assign storeEnable     = (state_reg == STORE);
   assign settling        = (state_reg == SETTLE);
   assign readStartOffset = {startHi_reg, startLo_reg};                // [R6]
   assign readbackMode    = mode_reg;
   assign regRdData       = rd_reg;

   // --------------------------------------------------------------
   // port clocks and self-test source
   // --------------------------------------------------------------
   port_clock_divider uParallelDiv (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .run     (parallelRun),
      .divCode (pDiv_reg),
      .portClk (parallelPortClk)
   );

   port_clock_divider uSerialDiv (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .run     (serialRun),
      .divCode (sDiv_reg),
      .portClk (serialPortClk)
   );

   self_test_pattern uPattern (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .sel     (sel_reg),
      .step    (testStep),
      .word    (testWord),
      .active  (testActive)
   );

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   sequence seqSettleDone;
      settling && settleCnt_reg >= settleTarget;
   endsequence

   AST_PDIV_RESET: assert property (@(posedge clk_sys) // [R2]
      $past(sys_rst) && !sys_rst |-> pDiv_reg == PDIV_RST)
      else $error("parallel divider reset value wrong");
   AST_STATUS_READ: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R4]
      regRead && regAddr == ADDR_FLAGS
      |=> regRdData == {5'h00, $past(overRange), $past(fifoEmpty), $past(fifoFull)})
      else $error("status byte wrong");
   AST_WORD_HI: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R5]
      regRead && regAddr == ADDR_WORD_HI |=> regRdData == {4'h0, $past(word_reg[11:8])})
      else $error("readout high nibble wrong");
   AST_OFFSET_HI: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R6]
      regWrite && regAddr == ADDR_START_HI
      |=> readStartOffset[13:8] == $past(regWrData[5:0]))
      else $error("offset high bits not taken");
   AST_SETTLE_END: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R10]
      seqSettleDone |=> storeEnable)
      else $error("store did not follow settle count");
   AST_SETTLE_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R10]
      settling && settleCnt_reg < settleTarget |=> !storeEnable)
      else $error("store began before settle count");
   AST_RESERVED_ZERO: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R11]
      regRead && regAddr == ADDR_MODE |=> regRdData[7:2] == 6'h00)
      else $error("reserved bits read nonzero");
endmodule
`default_nettype wire

// File: capture_fifo_readback_regs_tb_top.sv
/*
 * testbench for the capture register block: registers, dividers,
 * self-test patterns and the settle wait.
 * assumes the host model beside it.
 */
`timescale 1ns/10ps
`default_nettype none
module capture_fifo_readback_regs_tb_top
   import capture_regs_pkg::*;
;
   // ------------
   // signals and model state
   // ------------
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic [12:0] regAddr;
   logic [7:0]  regWrData, regRdData, q;
   logic        regWrite, regRead, fifoFull, fifoEmpty, overRange;
   logic [11:0] readoutWord, testWord, wordM, w, prev;
   logic        readoutValid, captureStart, fromStandby, storeEnable, settling;
   logic [13:0] readStartOffset;
   logic [1:0]  readbackMode;
   logic        parallelRun, serialRun, parallelPortClk, serialPortClk;
   logic        testStep, testActive;
   logic [7:0]  mdl [logic [12:0]];
   int          miscompares = 0;
   int          check_count = 0;
   logic [12:0] rwList [8] = '{ADDR_SETTLE_LO, ADDR_SETTLE_HI, ADDR_MODE,
      ADDR_START_LO, ADDR_START_HI, ADDR_PDIV, ADDR_SDIV, ADDR_SELFTEST};
   logic [12:0] roList [4] = '{ADDR_FLAGS, ADDR_WORD_LO, ADDR_WORD_HI, 13'h0108};
   logic [4:0]  codes [6] = '{5'h00, 5'h01, 5'h04, 5'h0F, 5'h10, 5'h1F};

   always #50 clk_sys = ~clk_sys;

   capture_fifo_readback_regs u_capture_fifo_readback_regs (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .fifoFull(fifoFull), .fifoEmpty(fifoEmpty), .overRange(overRange),
      .readoutWord(readoutWord), .readoutValid(readoutValid),
      .captureStart(captureStart), .fromStandby(fromStandby),
      .storeEnable(storeEnable), .settling(settling),
      .readStartOffset(readStartOffset), .readbackMode(readbackMode),
      .parallelRun(parallelRun), .serialRun(serialRun),
      .parallelPortClk(parallelPortClk), .serialPortClk(serialPortClk),
      .testStep(testStep), .testWord(testWord), .testActive(testActive));

   host_reg_model u_host_reg_model (.clk_sys(clk_sys), .regRdData(regRdData),
      .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
      .regRead(regRead));

   // ------------
   // model, compares and bus helpers
   // ------------
   // writable bits; zero marks read-only or unmapped
   function automatic logic [7:0] rwMask(input logic [12:0] a);
      case (a)
         ADDR_SETTLE_LO, ADDR_SETTLE_HI, ADDR_START_LO: return 8'hFF;
         ADDR_MODE:            return 8'h03;
         ADDR_START_HI:        return 8'h3F;
         ADDR_PDIV, ADDR_SDIV: return 8'h1F;
         ADDR_SELFTEST:        return 8'h0F;
         default:              return 8'h00;
      endcase
   endfunction

   function automatic logic [7:0] expRd(input logic [12:0] a);
      if (a == ADDR_FLAGS) return {5'h00, overRange, fifoEmpty, fifoFull};
      if (a == ADDR_WORD_LO) return wordM[7:0];
      if (a == ADDR_WORD_HI) return {4'h0, wordM[11:8]};
      if (rwMask(a) == 8'h00) return 8'h00;
      return mdl[a] & rwMask(a);
   endfunction

   task automatic chkVal(input string nm, input logic [13:0] e, input logic [13:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic chkCyc(input string nm, input int e, input int g);
      check_count++;
      if (g != e) begin
         miscompares++;
         $display("unexpected %s exp %0d got %0d", nm, e, g);
      end
   endtask

   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      u_host_reg_model.access(a, d, 1'b1, q);
      if (rwMask(a) != 8'h00) mdl[a] = d;
   endtask

   task automatic rdChk(input logic [12:0] a);
      logic [7:0] e;
      e = expRd(a);
      u_host_reg_model.access(a, 8'h00, 1'b0, q);
      chkVal($sformatf("reg %h", a), 14'(e), 14'(q));
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // period between the second and third rise
   task automatic divCheck(input int p, input logic [4:0] c);
      int   n = 0, last = 0, edges = 0;
      logic prv = 1'b0, cur;
      @(negedge clk_sys);
      if (p) serialRun = 1'b1;
      else parallelRun = 1'b1;
      for (int k = 0; k < 200 && edges < 3; k++) begin
         @(posedge clk_sys);
         #1;
         cur = p ? serialPortClk : parallelPortClk;
         if (cur === 1'b1 && prv === 1'b0) begin
            n = k - last;
            last = k;
            edges++;
         end
         prv = cur;
      end
      chkCyc("clock rises", 3, edges);
      if (edges < 3) conclude();
      chkCyc("divided period", 2 * ((c == 5'h00) ? 1 : (c[4] ? 16 : int'(c))), n);
      @(negedge clk_sys);
      {serialRun, parallelRun} = 2'b00;
      repeat (3) @(negedge clk_sys);
      chkVal("stopped clock", 14'h0000, 14'(p ? serialPortClk : parallelPortClk));
   endtask

   // one-cycle step; the registered word is read once landed
   task automatic stepW(output logic [11:0] o);
      @(negedge clk_sys);
      testStep = 1'b1;
      @(negedge clk_sys);
      testStep = 1'b0;
      o = testWord;
   endtask

   task automatic capture(input logic sb, input int t);
      int n;
      wr(ADDR_SETTLE_LO, 8'(t));
      wr(ADDR_SETTLE_HI, 8'(t >> 8));
      @(negedge clk_sys);
      captureStart = 1'b1;
      fromStandby = sb;
      @(negedge clk_sys);
      captureStart = 1'b0;
      chkVal("settling", 14'(sb), 14'(settling));
      n = 0;
      while (storeEnable !== 1'b1 && n < 400) begin
         @(negedge clk_sys);
         n++;
      end
      chkCyc("settle wait", sb ? t + 1 : 0, n);
      if (n >= 400) conclude();
      fifoFull = 1'b1;
      repeat (3) @(negedge clk_sys);
      chkVal("store after full", 14'h0000, 14'(storeEnable));
      fifoFull = 1'b0;
   endtask

   // ------------
   // main sequence
   // ------------
   initial begin
      void'($urandom(32'h817eb93d));
      {fifoFull, fifoEmpty, overRange, readoutValid, captureStart} = 5'h00;
      {fromStandby, parallelRun, serialRun, testStep} = 4'h0;
      readoutWord = 12'h000;
      wordM = 12'h000;
      foreach (rwList[i]) mdl[rwList[i]] = 8'h00;
      mdl[ADDR_PDIV] = 8'h04;
      mdl[ADDR_SDIV] = 8'h04;
      repeat (4) @(negedge clk_sys);
      sys_rst = 1'b0;
      // reset values, an unmapped place included
      foreach (rwList[i]) rdChk(rwList[i]);
      foreach (roList[i]) rdChk(roList[i]);
      divCheck(0, 5'h04);
      $display("test reset done");
      // random writes; reserved and read-only bits must not stick
      foreach (rwList[i]) wr(rwList[i], 8'($urandom));
      wr(ADDR_MODE, {6'($urandom), 2'($urandom_range(2))});
      wr(ADDR_FLAGS, 8'hFF);
      wr(13'h0108, 8'hFF);
      foreach (rwList[i]) rdChk(rwList[i]);
      rdChk(13'h0108);
      chkVal("offset", {mdl[ADDR_START_HI][5:0], mdl[ADDR_START_LO]}, readStartOffset);
      chkVal("mode", 14'(mdl[ADDR_MODE][1:0]), 14'(readbackMode));
      $display("test registers done");
      for (int k = 0; k < 8; k++) begin
         @(negedge clk_sys);
         {overRange, fifoEmpty, fifoFull} = 3'(k);
         rdChk(ADDR_FLAGS);
      end
      {overRange, fifoEmpty, fifoFull} = 3'b000;
      repeat (3) begin
         @(negedge clk_sys);
         readoutWord = 12'($urandom);
         readoutValid = 1'b1;
         wordM = readoutWord;
         @(negedge clk_sys);
         readoutValid = 1'b0;
         readoutWord = ~readoutWord;
         rdChk(ADDR_WORD_LO);
         rdChk(ADDR_WORD_HI);
      end
      $display("test status done");
      foreach (codes[i]) begin
         for (int p = 0; p < 2; p++) begin
            wr(p ? ADDR_SDIV : ADDR_PDIV, {3'($urandom), codes[i]});
            divCheck(p, codes[i]);
         end
      end
      $display("test dividers done");
      for (int s = 0; s < 16; s++) begin
         wr(ADDR_SELFTEST, 8'(s) | 8'hF0);
         chkVal("test active", 14'(s >= 1 && s <= 6), 14'(testActive));
         stepW(prev);
         for (int k = 0; k < 3; k++) begin
            stepW(w);
            case (s)
               1, 2: chkVal("checkerboard", 14'(prev ^ 12'hFFF), 14'(w));
               3: chkVal("ramp", 14'(12'(prev - 12'h001)), 14'(w));
               4: chkVal("pn moves", 14'h0001, 14'(w != prev));
               5: chkVal("plus one", 14'(WORD_PLUS1), 14'(w));
               6: chkVal("minus one", 14'(WORD_MINUS1), 14'(w));
               default: ;
            endcase
            prev = w;
         end
      end
      $display("test self-test done");
      capture(1'b0, 0);
      capture(1'b1, 0);
      capture(1'b1, 2);
      capture(1'b1, 300);
      capture(1'b1, $urandom_range(1, 40));
      $display("test capture done");
      conclude();
   end
endmodule
`default_nettype wire

// File: capture_regs_pkg.sv
/*
 * constants shared by the capture register block: register offsets,
 * field layouts, reset values and self-test selector codes.
 * assumes a 13-bit register address from the serial control front end.
 */
package capture_regs_pkg;
   // register offsets
   localparam logic [12:0] ADDR_SETTLE_LO   = 13'h0105;
   localparam logic [12:0] ADDR_SETTLE_HI   = 13'h0106;
   localparam logic [12:0] ADDR_MODE        = 13'h0107;
   localparam logic [12:0] ADDR_FLAGS       = 13'h010A;
   localparam logic [12:0] ADDR_WORD_LO     = 13'h010B;
   localparam logic [12:0] ADDR_WORD_HI     = 13'h010C;
   localparam logic [12:0] ADDR_START_LO    = 13'h010F;
   localparam logic [12:0] ADDR_START_HI    = 13'h0110;
   localparam logic [12:0] ADDR_PDIV        = 13'h0111;
   localparam logic [12:0] ADDR_SDIV        = 13'h0112;
   localparam logic [12:0] ADDR_SELFTEST    = 13'h013A;
   // field positions and widths
   localparam int MODE_W      = 2;
   localparam int START_HI_W  = 6;
   localparam int DIV_W       = 5;
   localparam int DIV_TOP     = 4;
   localparam int SEL_W       = 4;
   localparam int WORD_W      = 12;
   localparam int FLAG_FULL   = 0;
   localparam int FLAG_EMPTY  = 1;
   localparam int FLAG_OVR    = 2;
   // reset values
   localparam logic [7:0] SETTLE_RST = 8'h00;
   localparam logic [1:0] MODE_RST   = 2'h0;
   localparam logic [7:0] START_RST  = 8'h00;
   localparam logic [4:0] PDIV_RST   = 5'h04;
   localparam logic [4:0] SDIV_RST   = 5'h04;
   localparam logic [3:0] SEL_RST    = 4'h0;
   // divide ratio with top bit set is 2 x 16
   localparam logic [4:0] DIV_SATURATE = 5'h10;
   // self-test selector codes
   localparam logic [3:0] ST_OFF      = 4'h0;
   localparam logic [3:0] ST_CHECK_B  = 4'h1;
   localparam logic [3:0] ST_CHECK_A  = 4'h2;
   localparam logic [3:0] ST_RAMP     = 4'h3;
   localparam logic [3:0] ST_PN       = 4'h4;
   localparam logic [3:0] ST_PLUS1    = 4'h5;
   localparam logic [3:0] ST_MINUS1   = 4'h6;
   localparam logic [11:0] WORD_MINUS1 = 12'hFFF;
   localparam logic [11:0] WORD_PLUS1  = 12'h001;
   localparam logic [11:0] WORD_AAA    = 12'hAAA;
   localparam logic [11:0] WORD_555    = 12'h555;
   localparam logic [11:0] PN_SEED     = 12'hFFF;
   localparam logic [11:0] RAMP_START  = 12'hFFF;
   // readback modes
   localparam logic [1:0] RB_SLAVE    = 2'h0;
   localparam logic [1:0] RB_PARALLEL = 2'h1;
   localparam logic [1:0] RB_SERIAL   = 2'h2;
endpackage

// File: host_reg_model.sv
/*
 * host model driving the strobed register port.
 * assumes one access() call at a time.
 */
`timescale 1ns/10ps
`default_nettype none
module host_reg_model (
   input  wire logic        clk_sys,
   input  wire logic [7:0]  regRdData,
   output logic      [12:0] regAddr,
   output logic      [7:0]  regWrData,
   output logic             regWrite,
   output logic             regRead
);
   // idle bus at time zero
   initial begin
      {regAddr, regWrData, regWrite, regRead} = '0;
   end

   // drive at a falling edge, hold over one rising edge, then take data
   task automatic access(input logic [12:0] a, input logic [7:0] d,
                         input logic w, output logic [7:0] q);
      @(negedge clk_sys);
      regAddr   = a;
      regWrData = d;
      regWrite  = w;
      regRead   = !w;
      @(posedge clk_sys);
      @(negedge clk_sys);
      q         = regRdData;
      regWrite  = 1'b0;
      regRead   = 1'b0;
      // scrambled so nothing leans on stale values
      regAddr   = ~a;
      regWrData = ~d;
   endtask
endmodule
`default_nettype wire

// File: port_clock_divider.sv
/*
 * divides the sample clock down for a readback port: output period is
 * twice the 5-bit code; codes with the top bit set divide by 32.
 * assumes run is a same-clock level from the readback sequencer.
 */
`timescale 1ns/10ps
`default_nettype none
module port_clock_divider
   import capture_regs_pkg::*;
(
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   input  wire logic             run,
   input  wire logic [DIV_W-1:0] divCode,
   output logic                  portClk
);
   logic [DIV_W-1:0] half;
   logic [DIV_W-1:0] cnt_reg;
   logic [DIV_W-1:0] cnt_next;
   logic             clk_reg;
   logic             clk_next;

   // --------------------------------------------------------------
   // half period select
   // --------------------------------------------------------------
   // code zero has no defined ratio; treat it as one to avoid a stall
   always_comb begin
      if (divCode[DIV_TOP]) begin
         half = DIV_SATURATE;                          // [R3]
      end else if (divCode == '0) begin
         half = 5'h01;
      end else begin
         half = divCode;                               // [R1]
      end
   end

   // toggle every half cycles; idles low when not running
   always_comb begin
      cnt_next = cnt_reg + 5'h01;
      clk_next = clk_reg;
      if (!run) begin
         cnt_next = '0;
         clk_next = 1'b0;
      end else if (cnt_reg >= half - 5'h01) begin
         cnt_next = '0;
         clk_next = !clk_reg;                          // [R1]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cnt_reg <= '0;
         clk_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         clk_reg <= clk_next;
      end
   end

   assign portClk = clk_reg;

   AST_DIV_HALF: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R1]
      run && $past(run) && $changed(clk_reg) |-> $past(cnt_reg) == half - 5'h01)
      else $error("divider toggled at the wrong count");
   AST_DIV_TOP: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R3]
      run && $past(run) && $changed(clk_reg) && divCode[DIV_TOP]
      |-> $past(cnt_reg) == DIV_SATURATE - 5'h01)
      else $error("top divider bit did not saturate");
endmodule
`default_nettype wire

// File: self_test_pattern.sv
/*
 * built-in test pattern source for the capture memory.
 * assumes step is a one-cycle pulse per word to be written.
 */
`timescale 1ns/10ps
`default_nettype none
module self_test_pattern
   import capture_regs_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   input  wire logic [SEL_W-1:0]  sel,
   input  wire logic              step,
   output logic [WORD_W-1:0]      word,
   output logic                   active
);
   logic [WORD_W-1:0] word_reg;
   logic [WORD_W-1:0] word_next;
   logic [WORD_W-1:0] lfsr_reg;
   logic [WORD_W-1:0] lfsr_next;
   logic              phase_reg;
   logic              phase_next;

   // --------------------------------------------------------------
   // pattern step
   // --------------------------------------------------------------
   // reserved selector codes leave the pattern source idle
   always_comb begin
      word_next  = word_reg;
      lfsr_next  = lfsr_reg;
      phase_next = phase_reg;
      if (step) begin
         phase_next = !phase_reg;
         lfsr_next  = {lfsr_reg[10:0], lfsr_reg[11] ^ lfsr_reg[5] ^ lfsr_reg[3] ^ lfsr_reg[0]};
         unique case (sel)
            ST_CHECK_B: word_next = phase_reg ? WORD_AAA : WORD_555; // [R7]
            ST_CHECK_A: word_next = phase_reg ? WORD_555 : WORD_AAA; // [R7]
            ST_RAMP:    word_next = word_reg - 12'h001;              // [R7]
            ST_PN:      word_next = lfsr_reg;                        // [R9]
            ST_PLUS1:   word_next = WORD_PLUS1;                      // [R9]
            ST_MINUS1:  word_next = WORD_MINUS1;                     // [R8]
            default:    word_next = word_reg;                        // [R7]
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         word_reg  <= RAMP_START;
         lfsr_reg  <= PN_SEED;
         phase_reg <= 1'b0;
      end else begin
         word_reg  <= word_next;
         lfsr_reg  <= lfsr_next;
         phase_reg <= phase_next;
      end
   end

   assign word   = word_reg;
   assign active = (sel != ST_OFF) && (sel < 4'h7);  // [R7]

   AST_MINUS_ONE: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R8]
      step && sel == ST_MINUS1 |=> word == WORD_MINUS1)
      else $error("minus one pattern wrong");
   AST_PLUS_ONE: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R9]
      step && sel == ST_PLUS1 |=> word == WORD_PLUS1)
      else $error("plus one pattern wrong");
   AST_RESERVED_SEL: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R7]
      sel[3] || sel == 4'h7 |-> !active)
      else $error("reserved selector enabled pattern");
endmodule
`default_nettype wire
